// file: shared/rsim_pkg.sv
// constants, register map and carrier types for the shared event pin mux
// assumes a 125 MHz system clock and a 32-bit AXI4-Lite register port
package rsim_pkg;
  // clock and frequency-test timing
  localparam int CLK_HZ       = 125000000;
  localparam int FT_FREQ_HZ   = 512;
  // half period of the test square wave, rounded down
  localparam int FT_HALF_CYC  = CLK_HZ / (2 * FT_FREQ_HZ);
  localparam int FT_CNT_W     = 17;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CAL    = 8'h08;
  localparam logic [7:0] IDX_WDOG   = 8'h09;
  localparam logic [7:0] IDX_ALM1MO = 8'h0A;
  localparam logic [7:0] IDX_FLAGS  = 8'h0F;
  localparam logic [7:0] IDX_TMRCTL = 8'h11;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  // field positions
  localparam int BIT_LEVEL    = 7;
  localparam int BIT_FT       = 6;
  localparam int BIT_OSC_FAIL_IRQ_ENABLE     = 7;
  localparam int WD_MULT_HI   = 6;
  localparam int WD_MULT_LO   = 2;
  localparam int BIT_ALARM1_IRQ_ENABLE     = 7;
  localparam int BIT_ABE      = 5;
  localparam int BIT_OF       = 2;
  localparam int BIT_TIE      = 5;
  // reset values for first power-up
  localparam logic [7:0] RST_CAL    = 8'h80;
  localparam logic [7:0] RST_WDOG   = 8'h00;
  localparam logic [7:0] RST_ALM1MO = 8'h00;
  localparam logic [7:0] RST_TMRCTL = 8'h00;
  localparam logic       RST_OF     = 1'b1;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // interrupt requests from the source logic
  typedef struct packed {
    logic timer;
    logic alarm1;
    logic watchdog;
  } rsim_src_t;
endpackage : rsim_pkg

// file: src/rsim_top.sv
// shared open-drain event pin mux with its control registers
// assumes source requests come from logic on clk; supply state,
// oscillator stop and power-up strobe come from outside and are synced
`timescale 1ns/100ps

module rsim_top import rsim_pkg::*; #(
  parameter int FT_HALF_CYCLES = FT_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire rsim_src_t   src_req,
  input  wire logic        on_backup,
  input  wire logic        osc_stopped,
  input  wire logic        vcc_powerup,
  output logic             shared_event_pin_o,
  output logic             shared_event_pin_oe
);

  // register index from a byte address, 8'hFF when any address bit above bit 9 is set
  function automatic logic [7:0] reg_idx(input logic [31:0] a);
    return (a[31:10] == 22'h0) ? a[9:2] : 8'hFF;
  endfunction : reg_idx

  // map check shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] i);
    return (i == IDX_CAL) || (i == IDX_WDOG) || (i == IDX_ALM1MO) ||
           (i == IDX_FLAGS) || (i == IDX_TMRCTL) || (i == IDX_STATUS);
  endfunction : is_mapped

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [7:0]          cal_ff, wdog_ff, alm1mo_ff, tmrctl_ff;
  logic                of_ff;
  logic [2:0]          bk_sync_ff, os_sync_ff;
  logic [2:0]          pu_sync_ff;
  logic [FT_CNT_W-1:0] ft_cnt_ff;
  logic                sq_ff;
  logic                pin_oe_ff, pin_o_ff;
  logic                aw_got_ff, w_got_ff;
  logic [7:0]          aw_idx_ff;
  logic [7:0]          wdat_ff;
  logic                bvalid_ff, rvalid_ff;
  logic [1:0]          bresp_ff, rresp_ff;
  logic [31:0]         rdata_ff;

  // outside levels pass two flops before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bk_sync_ff <= 3'h0;
      os_sync_ff <= 3'h0;
      pu_sync_ff <= 3'h0;
    end else begin
      bk_sync_ff <= {bk_sync_ff[1:0], on_backup};
      os_sync_ff <= {os_sync_ff[1:0], osc_stopped};
      pu_sync_ff <= {pu_sync_ff[1:0], vcc_powerup};
    end
  end

  logic bk, osc_stop_s, pu_pulse;
  assign bk         = bk_sync_ff[1];
  assign osc_stop_s = os_sync_ff[1];
  assign pu_pulse   = pu_sync_ff[1] & ~pu_sync_ff[2]; // rising edge

  // control bits by name
  logic lvl, ft, osc_fail_irq_enable, alarm1_irq_enable, abe, timer_irq_enable, wd_run;
  assign lvl    = cal_ff[BIT_LEVEL];
  assign ft     = cal_ff[BIT_FT];
  assign osc_fail_irq_enable   = wdog_ff[BIT_OSC_FAIL_IRQ_ENABLE];
  assign alarm1_irq_enable   = alm1mo_ff[BIT_ALARM1_IRQ_ENABLE];
  assign abe    = alm1mo_ff[BIT_ABE];
  assign timer_irq_enable    = tmrctl_ff[BIT_TIE];
  assign wd_run = |wdog_ff[WD_MULT_HI:WD_MULT_LO];

  // write channel handshake: address and data in either order
  logic do_wr;
  assign do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      aw_idx_ff <= 8'h00;
      wdat_ff   <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_idx_ff <= reg_idx(s_axi_awaddr);
      end else if (do_wr) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdat_ff  <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end else if (do_wr) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // write data lane 0 enable kept with the data
  logic wstrb0_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wstrb0_ff <= s_axi_wstrb[0];
    end
  end

  logic wr_hit;
  assign wr_hit = do_wr & wstrb0_ff;

  // write response, slverr for unmapped index
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= is_mapped(aw_idx_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_b_hold;
    bvalid_ff && !s_axi_bready |=> bvalid_ff;
  endproperty

  // control registers; later power-up clears ft and watchdog
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cal_ff    <= RST_CAL;
      wdog_ff   <= RST_WDOG;
      alm1mo_ff <= RST_ALM1MO;
      tmrctl_ff <= RST_TMRCTL;
    end else if (pu_pulse) begin
      cal_ff[BIT_FT] <= 1'b0;
      wdog_ff[WD_MULT_HI:0] <= 7'h00;
    end else if (wr_hit) begin
      case (aw_idx_ff)
        IDX_CAL:    cal_ff    <= wdat_ff;
        IDX_WDOG:   wdog_ff   <= wdat_ff;
        IDX_ALM1MO: alm1mo_ff <= wdat_ff;
        IDX_TMRCTL: tmrctl_ff <= wdat_ff;
        default: ;
      endcase
    end
  end

  a_pu_clear: assert property (p_pu_clear) else $error("ft kept");
  property p_pu_clear;
    pu_pulse |=> !cal_ff[BIT_FT] && !wd_run;
  endproperty

  // osc fail flag: set by a stopped oscillator, cleared only by
  // writing zero; the set wins over a clear in the same cycle
  logic of_clr;
  assign of_clr = wr_hit && aw_idx_ff == IDX_FLAGS && !wdat_ff[BIT_OF];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      of_ff <= RST_OF;
    end else if (osc_stop_s) begin
      of_ff <= 1'b1;
    end else if (of_clr) begin
      of_ff <= 1'b0;
    end
  end

  a_of_sticky: assert property (p_of_sticky) else $error("of lost");
  property p_of_sticky;
    of_ff && !of_clr |=> of_ff;
  endproperty

  // read channel; reading flags has no side effect
  logic [7:0] ar_idx;
  assign ar_idx = reg_idx(s_axi_araddr);

  logic irq_act, any_en;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      case (ar_idx)
        IDX_CAL:    rdata_ff <= {24'h0, cal_ff};
        IDX_WDOG:   rdata_ff <= {24'h0, wdog_ff};
        IDX_ALM1MO: rdata_ff <= {24'h0, alm1mo_ff};
        IDX_TMRCTL: rdata_ff <= {24'h0, tmrctl_ff};
        IDX_FLAGS:  rdata_ff <= 32'(of_ff) << BIT_OF;
        IDX_STATUS: rdata_ff <= {28'h0, irq_act, any_en, bk,
                                 pin_oe_ff};
        default:    rdata_ff <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // 512 Hz test square wave from the system clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ft_cnt_ff <= '0;
      sq_ff     <= 1'b0;
    end else if (ft_cnt_ff == FT_CNT_W'(FT_HALF_CYCLES - 1)) begin
      ft_cnt_ff <= '0;
      sq_ff     <= ~sq_ff;
    end else begin
      ft_cnt_ff <= ft_cnt_ff + 1'b1;
    end
  end

  a_sq_period: assert property (p_sq_period) else $error("bad period");
  property p_sq_period;
    $changed(sq_ff) |->
      $past(ft_cnt_ff) == FT_CNT_W'(FT_HALF_CYCLES - 1);
  endproperty

  // combined request; backup drops timer and watchdog
  logic irq_any_vcc, irq_any_bk;
  assign irq_any_bk  = (osc_fail_irq_enable & of_ff) | (alarm1_irq_enable & src_req.alarm1);
  assign irq_any_vcc = irq_any_bk | (timer_irq_enable & src_req.timer) |
                       (wd_run & src_req.watchdog);
  assign irq_act = bk ? irq_any_bk : irq_any_vcc;
  assign any_en  = bk ? (alarm1_irq_enable | osc_fail_irq_enable)
                      : (alarm1_irq_enable | osc_fail_irq_enable | timer_irq_enable | wd_run);

  // pin priority: true means pull the pin low
  logic nxt_pin_low;
  always_comb begin
    if (bk) begin
      if (!abe) begin
        nxt_pin_low = 1'b0;
      end else if (!lvl) begin
        nxt_pin_low = 1'b1;
      end else if (!any_en) begin
        nxt_pin_low = 1'b0;
      end else begin
        nxt_pin_low = irq_act;
      end
    end else begin
      if (!lvl && !ft) begin
        nxt_pin_low = 1'b1;
      end else if (ft && (!lvl || !any_en)) begin
        nxt_pin_low = ~sq_ff;
      end else if (lvl && any_en) begin
        nxt_pin_low = irq_act;
      end else begin
        nxt_pin_low = 1'b0;
      end
    end
  end

  // open drain: only ever drive zero, enable when low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_oe_ff <= 1'b0;
      pin_o_ff  <= 1'b0;
    end else begin
      pin_oe_ff <= nxt_pin_low;
      pin_o_ff  <= 1'b0;
    end
  end

  a_vcc_low: assert property (p_vcc_low) else $error("pin not low");
  property p_vcc_low;
    !bk && !lvl && !ft |=> pin_oe_ff;
  endproperty

  a_vcc_rel: assert property (p_vcc_rel) else $error("pin not off");
  property p_vcc_rel;
    !bk && lvl && !ft && !any_en |=> !pin_oe_ff;
  endproperty

  a_vcc_ft: assert property (p_vcc_ft) else $error("no test wave");
  property p_vcc_ft;
    !bk && ft && !lvl |=> pin_oe_ff != $past(sq_ff);
  endproperty

  a_bk_noabe: assert property (p_bk_noabe) else $error("abe ignored");
  property p_bk_noabe;
    bk && !abe |=> !pin_oe_ff;
  endproperty

  a_bk_low: assert property (p_bk_low) else $error("backup not low");
  property p_bk_low;
    bk && abe && !lvl |=> pin_oe_ff;
  endproperty

  a_bk_noen: assert property (p_bk_noen) else $error("backup not off");
  property p_bk_noen;
    bk && lvl && !alarm1_irq_enable && !osc_fail_irq_enable |=> !pin_oe_ff;
  endproperty

  a_bk_irq: assert property (p_bk_irq) else $error("backup irq lost");
  property p_bk_irq;
    bk && abe && lvl && osc_fail_irq_enable && of_ff |=> pin_oe_ff;
  endproperty

  a_bk_notmr: assert property (p_bk_notmr) else $error("timer in bk");
  property p_bk_notmr;
    bk && abe && lvl && !osc_fail_irq_enable && alarm1_irq_enable && !src_req.alarm1
      |=> !pin_oe_ff;
  endproperty

  a_od_zero: assert property (p_od_zero) else $error("drove high");
  property p_od_zero;
    pin_oe_ff |-> !pin_o_ff;
  endproperty

  // outputs from flops; awready, wready and arready are inverted
  assign s_axi_awready       = ~aw_got_ff;
  assign s_axi_wready        = ~w_got_ff;
  assign s_axi_bvalid        = bvalid_ff;
  assign s_axi_bresp         = bresp_ff;
  assign s_axi_arready       = ~rvalid_ff;
  assign s_axi_rvalid        = rvalid_ff;
  assign s_axi_rdata         = rdata_ff;
  assign s_axi_rresp         = rresp_ff;
  assign shared_event_pin_o  = pin_o_ff;
  assign shared_event_pin_oe = pin_oe_ff;

endmodule : rsim_top

// file: verification/rsim_host.sv
// host interrupt input model for the shared event pin
// assumes the pin is open drain with a pull-up on the board
`timescale 1ns/100ps
module rsim_host import rsim_pkg::*; (
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_level,
  output int        fall_count
);
  // pull-up supplies the high level when the pin is released
  assign pin_level = pin_oe ? pin_o : 1'b1;
  // host edge detector counts falling edges of its interrupt input
  initial fall_count = 0;
  always @(negedge pin_level) fall_count++;
endmodule : rsim_host

// file: verification/tb_rsim_top.sv
// self-checking bench for the shared event pin mux
// assumes rsim_top with a short test wave and the host pin model
`timescale 1ns/100ps
module tb_rsim_top import rsim_pkg::*;;
  localparam int HC = 8;
  logic        clk, resetn, pin;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, r;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, e;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  rsim_src_t   src_req;
  logic        on_backup, osc_stopped, vcc_powerup;
  logic        shared_event_pin_o, shared_event_pin_oe;
  int          miscompares, check_count, f, falls;

  // block under test and the host side of its pin
  rsim_top #(.FT_HALF_CYCLES(HC)) rsim_top_inst (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_req, .on_backup, .osc_stopped,
    .vcc_powerup, .shared_event_pin_o, .shared_event_pin_oe
  );
  rsim_host rsim_host_inst (
    .clk, .pin_o(shared_event_pin_o), .pin_oe(shared_event_pin_oe),
    .pin_level(pin), .fall_count(falls)
  );

  // compare a bus value
  task automatic cmp_val(input logic [31:0] got, exp, input string w);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask : cmp_val

  // compare the pin level seen by the host
  task automatic cmp_pin(input logic exp);
    check_count++;
    if (pin !== exp || shared_event_pin_o !== 1'b0) begin
      miscompares++;
      $display("unexpected at %0t: pin %b exp %b", $time, pin, exp);
    end
  endtask : cmp_pin

  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle

  // one write, address and data offered together
  task automatic axi_wr(input logic [7:0] idx, d,
                        input logic [1:0] er = RESP_OKAY);
    int n = 0;
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    @(posedge clk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // handshakes judged on settled values before each rising edge
    do begin
      @(negedge clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      n++;
    end while (!b_hs && n < 64);
    s_axi_bready <= 1'b0;
    cmp_val(32'(b_hs), 32'h1, "bvalid");
    cmp_val(resp, er, "bresp");
  endtask : axi_wr

  // one read, data and response compared at the handshake
  task automatic axi_rd(input logic [7:0] idx, d,
                        input logic [1:0] er = RESP_OKAY);
    int n = 0;
    logic ar_hs, r_hs;
    logic [31:0] data;
    logic [1:0] resp;
    @(posedge clk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // data and response taken at the edge where rvalid stands
    do begin
      @(negedge clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid === 1'b1;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      n++;
    end while (!r_hs && n < 64);
    s_axi_rready <= 1'b0;
    cmp_val(32'(r_hs), 32'h1, "rvalid");
    cmp_val(data, {24'h0, d}, "rdata");
    cmp_val(resp, er, "rresp");
  endtask : axi_rd

  // expected pin: 0 low, 1 released, 2 test wave
  function automatic logic [1:0] exp_pin(input logic [31:0] v);
    logic irq, en;
    if (v[0]) begin
      en = v[3] | v[4];
      irq = (v[3] & v[10]) | (v[4] & v[8]);
      if (!v[7] || (v[1] && !en)) return 2'h1;
      if (!v[1]) return 2'h0;
      return {1'b0, !irq};
    end
    en = v[3] | v[4] | v[5] | v[6];
    irq = (v[5] & v[11]) | (v[3] & v[10]) | (v[4] & v[8]) | (v[6] & v[9]);
    if (!v[1] && !v[2]) return 2'h0;
    if (v[2] && (!v[1] || !en)) return 2'h2;
    if (v[1] && en) return {1'b0, !irq};
    return 2'h1;
  endfunction : exp_pin

  // measure one half period of the test wave
  task automatic chk_wave();
    logic p;
    int n;
    for (int k = 0; k < 2; k++) begin
      p = pin;
      n = 0;
      while (pin === p && n < 4 * HC) begin
        @(negedge clk);
        n++;
      end
    end
    cmp_val(n, HC, "half period");
  endtask : chk_wave

  // reset held six cycles, then defaults checked
  task automatic reset_defaults();
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    settle();
    cmp_pin(1'b1);
    axi_rd(IDX_CAL, 8'h80);
    axi_rd(IDX_WDOG, 8'h00);
    axi_rd(IDX_ALM1MO, 8'h00);
    axi_rd(IDX_TMRCTL, 8'h00);
    axi_rd(IDX_FLAGS, 8'h04);
    axi_rd(IDX_STATUS, 8'h00);
  endtask : reset_defaults

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog against a hung handshake
  initial begin
    #600000;
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    src_req = '0;
    {on_backup, osc_stopped, vcc_powerup} = '0;
    miscompares = 0;
    check_count = 0;
    void'($urandom(32587));
    reset_defaults();
    axi_wr(8'h30, 8'hFF, RESP_SLVERR);
    axi_rd(8'h30, 8'h00, RESP_SLVERR);
    // overlapping sources and the sticky osc fail flag
    axi_wr(IDX_WDOG, 8'h80);
    axi_wr(IDX_ALM1MO, 8'h80);
    axi_wr(IDX_FLAGS, 8'h00);
    settle();
    cmp_pin(1'b1);
    f = falls;
    src_req <= 3'b010;
    settle();
    cmp_pin(1'b0);
    osc_stopped <= 1'b1;
    settle();
    osc_stopped <= 1'b0;
    src_req <= 3'b000;
    settle();
    cmp_pin(1'b0);
    cmp_val(falls, f + 1, "falls");
    axi_rd(IDX_FLAGS, 8'h04);
    cmp_pin(1'b0);
    axi_wr(IDX_WDOG, 8'h00);
    settle();
    cmp_pin(1'b1);
    axi_wr(IDX_WDOG, 8'h80);
    repeat (2) @(posedge clk);
    cmp_pin(1'b0);
    axi_wr(IDX_FLAGS, 8'h00);
    settle();
    cmp_pin(1'b1);
    // later power-up clears test and watchdog bits only
    axi_wr(IDX_CAL, 8'h40);
    axi_wr(IDX_WDOG, 8'h84);
    vcc_powerup <= 1'b1;
    settle();
    vcc_powerup <= 1'b0;
    axi_rd(IDX_CAL, 8'h00);
    axi_rd(IDX_WDOG, 8'h80);
    axi_rd(IDX_ALM1MO, 8'h80);
    cmp_pin(1'b0);
    // random settings across both supplies
    for (int i = 0; i < 80; i++) begin
      r = $urandom;
      on_backup <= r[0];
      osc_stopped <= r[8];
      src_req <= r[11:9];
      axi_wr(IDX_CAL, {r[1], r[2], 6'h00});
      axi_wr(IDX_WDOG, {r[4], 4'h0, r[6], 2'h0});
      axi_wr(IDX_ALM1MO, {r[3], 1'b0, r[7], 5'h00});
      axi_wr(IDX_TMRCTL, {2'h0, r[5], 5'h00});
      settle();
      e = exp_pin(r);
      if (e == 2'h2) chk_wave();
      else cmp_pin(e[0]);
      osc_stopped <= 1'b0;
      settle();
      axi_wr(IDX_FLAGS, 8'h00);
    end
    on_backup <= 1'b0;
    reset_defaults();
    print_verdict();
  end
endmodule : tb_rsim_top
